// ===== rtl/sbio_pkg.sv
// Purpose: Constants and types shared by the six-bit I/O port
// Assumes: Byte-wide register port, one register per address
// Notes:   Reset values are the power-on settings of the port
package sbio_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int PIN_COUNT     = 6;
    localparam int ADDR_W        = 4;
    localparam int DATA_W        = 8;
    localparam int RESET_PIN_IDX = 3;

    typedef logic [ADDR_W-1:0]    sbio_addr_type;
    typedef logic [DATA_W-1:0]    sbio_data_type;
    typedef logic [PIN_COUNT-1:0] sbio_pins_type;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam sbio_addr_type OFF_PIN_LEVEL = 4'h0;
    localparam sbio_addr_type OFF_LATCH     = 4'h1;
    localparam sbio_addr_type OFF_DIRECTION = 4'h2;
    localparam sbio_addr_type OFF_ANALOG    = 4'h3;
    localparam sbio_addr_type OFF_DRAIN     = 4'h4;
    localparam sbio_addr_type OFF_SLEW      = 4'h5;
    localparam sbio_addr_type OFF_THRESHOLD = 4'h6;
    localparam sbio_addr_type OFF_PULLUP    = 4'h7;
    localparam sbio_addr_type OFF_PIN_SEL   = 4'h8;
    localparam sbio_addr_type OFF_PIN_SET   = 4'h9;
    localparam sbio_addr_type OFF_PIN_CLR   = 4'ha;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam sbio_pins_type RST_LATCH     = 6'h00;
    localparam sbio_pins_type RST_DIRECTION = 6'h3f;
    localparam sbio_pins_type RST_ANALOG    = 6'h3f;
    localparam sbio_pins_type RST_DRAIN     = 6'h00;
    localparam sbio_pins_type RST_SLEW      = 6'h3f;
    localparam sbio_pins_type RST_THRESHOLD = 6'h3f;
    localparam sbio_pins_type RST_PULLUP    = 6'h00;
    localparam sbio_pins_type RST_PIN_SEL   = 6'h00;
    localparam sbio_data_type RST_RDATA     = 8'h00;
    localparam sbio_data_type READ_ZERO     = 8'h00;

endpackage

// ===== rtl/sbio_pad_if.sv
// Purpose: Carries pin settings from the registers to the pad drivers
// Assumes: All signals on the system clock
// Notes:   Pad side is purely combinational
`timescale 1ns/1ps
interface sbio_pad_if;
    sbio_pkg::sbio_pins_type direction;
    sbio_pkg::sbio_pins_type latch;
    sbio_pkg::sbio_pins_type drain;
    sbio_pkg::sbio_pins_type pullup_en;
    sbio_pkg::sbio_pins_type pin_sel;
    sbio_pkg::sbio_pins_type periph_data;
    sbio_pkg::sbio_pins_type twi_own;
    sbio_pkg::sbio_pins_type analog_out_en;
    logic                    reset_pin_enable;
    sbio_pkg::sbio_pins_type pad_out;
    sbio_pkg::sbio_pins_type pad_oe;
    sbio_pkg::sbio_pins_type pad_pullup;

    modport regs (
        output direction, latch, drain, pullup_en, pin_sel, periph_data,
        output twi_own, analog_out_en, reset_pin_enable,
        input  pad_out, pad_oe, pad_pullup
    );
    modport pad (
        input  direction, latch, drain, pullup_en, pin_sel, periph_data,
        input  twi_own, analog_out_en, reset_pin_enable,
        output pad_out, pad_oe, pad_pullup
    );
endinterface

// ===== rtl/sbio_sync.sv
// Purpose: Two-stage synchroniser for pin levels
// Assumes: Inputs asynchronous to clk
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module sbio_sync #(
    parameter int WIDTH = 6
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_b,
    // Data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule // sbio_sync

// ===== rtl/sbio_pad_ctrl.sv
// Purpose: Per-pin output source, driver and pull-up control
// Assumes: Settings already registered by the port
// Notes:   Open-drain releases the pin for a high level
`timescale 1ns/1ps
module sbio_pad_ctrl (
    // Settings and pad controls
    sbio_pad_if.pad pads
);
    for (genvar i = 0; i < sbio_pkg::PIN_COUNT; i++) begin : g_pin
        // Peripheral or two-wire owner replaces the latch
        wire use_periph = pads.pin_sel[i] | pads.twi_own[i];
        wire source     = use_periph ? pads.periph_data[i]
                                     : pads.latch[i];
        wire open_drain = pads.drain[i] | pads.twi_own[i];
        // Direction one or analog output releases the driver
        wire drive_en   = ~pads.direction[i]
                        & ~pads.analog_out_en[i];
        wire force_pu   = (i == sbio_pkg::RESET_PIN_IDX)
                        & pads.reset_pin_enable;

        assign pads.pad_oe[i]     = drive_en & (~open_drain | ~source);
        assign pads.pad_out[i]    = ~open_drain & source;
        assign pads.pad_pullup[i] = (pads.pullup_en[i] & pads.direction[i])
                                  | force_pu;
    end
endmodule // sbio_pad_ctrl

// ===== rtl/sbio_port.sv
// Purpose: Six-bit general-purpose I/O port with per-pin controls
// Assumes: Pad cell applies pull-up, slew and threshold settings
// Notes:   Pin levels pass a two-stage synchroniser before reads
//
// Overview of operation
// - Six pins, each with own controls
// - Direction one turns the driver off
// - Direction zero drives the latch value
// - Pin register reads pins, writes latch
// - Latch write equals pin write; reads latch
// - Latch holds the newest written value
// - Set and clear writes are read-modify-write; port writes replace all bits
// - Analog select blocks input, reads zero
// - Analog select leaves digital output alone
// - Analog select resets to analog mode
// - Latch is the default output source
// - Analog inputs live; digital outputs still drive
// - Analog output forces the driver off
// - Peripheral owns output; level still readable
// - Direction governs drivers on analog pins
// - Open-drain sinks only; else push-pull
// - Two-wire owner makes pin open-drain
// - Slew bit limits edge rate
// - Threshold select picks Schmitt or TTL
// - Per-pin weak pull-up enable
// - Pull-up off while pin drives
// - Reset-pin function forces pin three pull-up
`timescale 1ns/1ps
module sbio_port (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst_b,
    // Register port
    input  wire sbio_pkg::sbio_addr_type reg_addr,
    input  wire sbio_pkg::sbio_data_type reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output sbio_pkg::sbio_data_type      reg_rdata,
    // On-chip peripherals
    input  wire sbio_pkg::sbio_pins_type periph_data,
    input  wire sbio_pkg::sbio_pins_type twi_own,
    input  wire sbio_pkg::sbio_pins_type analog_out_en,
    input  wire logic                    reset_pin_enable,
    output sbio_pkg::sbio_pins_type      digital_in,
    // Pads
    input  wire sbio_pkg::sbio_pins_type pad_in,
    output sbio_pkg::sbio_pins_type      pad_out,
    output sbio_pkg::sbio_pins_type      pad_oe,
    output sbio_pkg::sbio_pins_type      pad_pullup,
    output sbio_pkg::sbio_pins_type      pad_slew_limit,
    output sbio_pkg::sbio_pins_type      pad_schmitt,
    output sbio_pkg::sbio_pins_type      pad_in_enable
);

    // ************************************************************
    // Address decode
    // ************************************************************
    function automatic logic hit(input sbio_pkg::sbio_addr_type addr,
                                 input sbio_pkg::sbio_addr_type off);
        hit = (addr == off);
    endfunction

    wire wr_pin   = reg_wr & hit(reg_addr, sbio_pkg::OFF_PIN_LEVEL);
    wire wr_latch = reg_wr & hit(reg_addr, sbio_pkg::OFF_LATCH);
    wire wr_dir   = reg_wr & hit(reg_addr, sbio_pkg::OFF_DIRECTION);
    wire wr_ana   = reg_wr & hit(reg_addr, sbio_pkg::OFF_ANALOG);
    wire wr_drain = reg_wr & hit(reg_addr, sbio_pkg::OFF_DRAIN);
    wire wr_slew  = reg_wr & hit(reg_addr, sbio_pkg::OFF_SLEW);
    wire wr_thr   = reg_wr & hit(reg_addr, sbio_pkg::OFF_THRESHOLD);
    wire wr_pu    = reg_wr & hit(reg_addr, sbio_pkg::OFF_PULLUP);
    wire wr_psel  = reg_wr & hit(reg_addr, sbio_pkg::OFF_PIN_SEL);
    wire wr_set   = reg_wr & hit(reg_addr, sbio_pkg::OFF_PIN_SET);
    wire wr_clr   = reg_wr & hit(reg_addr, sbio_pkg::OFF_PIN_CLR);

    // ************************************************************
    // Registers
    // ************************************************************
    sbio_pkg::sbio_pins_type output_latch_reg;
    sbio_pkg::sbio_pins_type direction_reg;
    sbio_pkg::sbio_pins_type analog_select_reg;
    sbio_pkg::sbio_pins_type drain_mode_reg;
    sbio_pkg::sbio_pins_type slew_limit_reg;
    sbio_pkg::sbio_pins_type threshold_select_reg;
    sbio_pkg::sbio_pins_type pullup_enable_reg;
    sbio_pkg::sbio_pins_type peripheral_pin_select_reg;
    sbio_pkg::sbio_data_type rdata_reg;

    sbio_pkg::sbio_pins_type output_latch_next;
    sbio_pkg::sbio_pins_type direction_next;
    sbio_pkg::sbio_pins_type analog_select_next;
    sbio_pkg::sbio_pins_type drain_mode_next;
    sbio_pkg::sbio_pins_type slew_limit_next;
    sbio_pkg::sbio_pins_type threshold_select_next;
    sbio_pkg::sbio_pins_type pullup_enable_next;
    sbio_pkg::sbio_pins_type peripheral_pin_select_next;
    sbio_pkg::sbio_data_type rdata_next;

    // ************************************************************
    // Pin sampling
    // ************************************************************
    sbio_pkg::sbio_pins_type pin_sync;
    sbio_pkg::sbio_pins_type pin_read;

    sbio_sync #(
        .WIDTH (sbio_pkg::PIN_COUNT)
    ) u_pin_sync (
        .clk      (clk),
        .rst_b    (rst_b),
        .async_in (pad_in),
        .sync_out (pin_sync)
    );

    // Analog pins read zero; pads already apply the threshold
    assign pin_read      = pin_sync & ~analog_select_reg;
    assign digital_in    = pin_read;
    assign pad_in_enable = ~analog_select_reg;
    assign pad_schmitt   = threshold_select_reg;
    assign pad_slew_limit = slew_limit_reg;

    // ************************************************************
    // Next values
    // ************************************************************
    // Whole-port writes replace every bit; set and clear keep the rest
    // from the pins, so analog pins come back as zero.
    wire [sbio_pkg::PIN_COUNT-1:0] wdata_pins =
        reg_wdata[sbio_pkg::PIN_COUNT-1:0];

    assign output_latch_next =
        (wr_pin | wr_latch) ? wdata_pins :
        wr_set              ? (pin_read | wdata_pins) :
        wr_clr              ? (pin_read & ~wdata_pins) :
                              output_latch_reg;
    assign direction_next        = wr_dir   ? wdata_pins : direction_reg;
    assign analog_select_next    = wr_ana   ? wdata_pins : analog_select_reg;
    assign drain_mode_next       = wr_drain ? wdata_pins : drain_mode_reg;
    assign slew_limit_next       = wr_slew  ? wdata_pins : slew_limit_reg;
    assign threshold_select_next = wr_thr   ? wdata_pins : threshold_select_reg;
    assign pullup_enable_next    = wr_pu    ? wdata_pins : pullup_enable_reg;
    assign peripheral_pin_select_next =
        wr_psel ? wdata_pins : peripheral_pin_select_reg;

    // Read mux; unmapped addresses read zero
    wire sbio_pkg::sbio_pins_type read_mux =
        hit(reg_addr, sbio_pkg::OFF_PIN_LEVEL) ? pin_read :
        hit(reg_addr, sbio_pkg::OFF_LATCH)     ? output_latch_reg :
        hit(reg_addr, sbio_pkg::OFF_DIRECTION) ? direction_reg :
        hit(reg_addr, sbio_pkg::OFF_ANALOG)    ? analog_select_reg :
        hit(reg_addr, sbio_pkg::OFF_DRAIN)     ? drain_mode_reg :
        hit(reg_addr, sbio_pkg::OFF_SLEW)      ? slew_limit_reg :
        hit(reg_addr, sbio_pkg::OFF_THRESHOLD) ? threshold_select_reg :
        hit(reg_addr, sbio_pkg::OFF_PULLUP)    ? pullup_enable_reg :
        hit(reg_addr, sbio_pkg::OFF_PIN_SEL)   ? peripheral_pin_select_reg :
                                                 '0;

    assign rdata_next = reg_rd
        ? {{(sbio_pkg::DATA_W - sbio_pkg::PIN_COUNT){1'b0}}, read_mux}
        : sbio_pkg::READ_ZERO;

    // ************************************************************
    // State
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            output_latch_reg          <= sbio_pkg::RST_LATCH;
            direction_reg             <= sbio_pkg::RST_DIRECTION;
            analog_select_reg         <= sbio_pkg::RST_ANALOG;
            drain_mode_reg            <= sbio_pkg::RST_DRAIN;
            slew_limit_reg            <= sbio_pkg::RST_SLEW;
            threshold_select_reg      <= sbio_pkg::RST_THRESHOLD;
            pullup_enable_reg         <= sbio_pkg::RST_PULLUP;
            peripheral_pin_select_reg <= sbio_pkg::RST_PIN_SEL;
            rdata_reg                 <= sbio_pkg::RST_RDATA;
        end else begin
            output_latch_reg          <= output_latch_next;
            direction_reg             <= direction_next;
            analog_select_reg         <= analog_select_next;
            drain_mode_reg            <= drain_mode_next;
            slew_limit_reg            <= slew_limit_next;
            threshold_select_reg      <= threshold_select_next;
            pullup_enable_reg         <= pullup_enable_next;
            peripheral_pin_select_reg <= peripheral_pin_select_next;
            rdata_reg                 <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;

    // ************************************************************
    // Pad drivers
    // ************************************************************
    sbio_pad_if pads ();

    // Analog select is not routed to the drivers at all
    assign pads.direction        = direction_reg;
    assign pads.latch            = output_latch_reg;
    assign pads.drain            = drain_mode_reg;
    assign pads.pullup_en        = pullup_enable_reg;
    assign pads.pin_sel          = peripheral_pin_select_reg;
    assign pads.periph_data      = periph_data;
    assign pads.twi_own          = twi_own;
    assign pads.analog_out_en    = analog_out_en;
    assign pads.reset_pin_enable = reset_pin_enable;

    sbio_pad_ctrl u_pad_ctrl (
        .pads (pads.pad)
    );

    assign pad_out    = pads.pad_out;
    assign pad_oe     = pads.pad_oe;
    assign pad_pullup = pads.pad_pullup;

    // ************************************************************
    // Checks
    // ************************************************************
    wire sbio_pkg::sbio_pins_type plain_out =
        ~direction_reg & ~drain_mode_reg & ~analog_out_en
        & ~peripheral_pin_select_reg & ~twi_own;
    wire sbio_pkg::sbio_pins_type od_mask = drain_mode_reg | twi_own;
    wire sbio_pkg::sbio_pins_type pu_force =
        reset_pin_enable ? sbio_pkg::sbio_pins_type'(1 << sbio_pkg::RESET_PIN_IDX)
                         : '0;

    a_dir_input_off: assert property (
        @(posedge clk) disable iff (!rst_b)
        (pad_oe & direction_reg) == '0)
        else $error("driver on for an input pin");

    a_out_drives_latch: assert property (
        @(posedge clk) disable iff (!rst_b)
        ((pad_oe & plain_out) == plain_out)
        && ((pad_out & plain_out) == (output_latch_reg & plain_out)))
        else $error("output pin not driving latch");

    a_pin_read_level: assert property (
        @(posedge clk) disable iff (!rst_b)
        reg_rd && reg_addr == sbio_pkg::OFF_PIN_LEVEL
        |=> reg_rdata[sbio_pkg::PIN_COUNT-1:0] == $past(pin_read))
        else $error("pin read wrong");

    a_latch_read_back: assert property (
        @(posedge clk) disable iff (!rst_b)
        reg_rd && reg_addr == sbio_pkg::OFF_LATCH
        |=> reg_rdata[sbio_pkg::PIN_COUNT-1:0] == $past(output_latch_reg))
        else $error("latch read wrong");

    a_write_to_latch: assert property (
        @(posedge clk) disable iff (!rst_b)
        reg_wr && (reg_addr == sbio_pkg::OFF_PIN_LEVEL
                   || reg_addr == sbio_pkg::OFF_LATCH)
        |=> output_latch_reg == $past(reg_wdata[sbio_pkg::PIN_COUNT-1:0]))
        else $error("latch missed write");

    a_rmw_set_bits: assert property (
        @(posedge clk) disable iff (!rst_b)
        reg_wr && reg_addr == sbio_pkg::OFF_PIN_SET
        |=> output_latch_reg
            == ($past(pin_read) | $past(reg_wdata[sbio_pkg::PIN_COUNT-1:0])))
        else $error("set not read-modify-write");

    a_analog_reads_zero: assert property (
        @(posedge clk) disable iff (!rst_b)
        ((digital_in & analog_select_reg) == '0)
        && ((pad_in_enable & analog_select_reg) == '0))
        else $error("analog pin read as digital");

    a_reset_defaults: assert property (
        @(posedge clk)
        !rst_b |=> analog_select_reg == sbio_pkg::RST_ANALOG
                   && peripheral_pin_select_reg == sbio_pkg::RST_PIN_SEL)
        else $error("reset defaults wrong");

    a_analog_out_hiz: assert property (
        @(posedge clk) disable iff (!rst_b)
        (pad_oe & analog_out_en) == '0)
        else $error("driver on under analog output");

    a_open_drain_sink: assert property (
        @(posedge clk) disable iff (!rst_b)
        (pad_oe & pad_out & od_mask) == '0)
        else $error("open-drain pin sourcing");

    a_pullup_when_out: assert property (
        @(posedge clk) disable iff (!rst_b)
        (pad_pullup & ~direction_reg & ~pu_force) == '0)
        else $error("pull-up on an output");

    a_reset_pin_pu: assert property (
        @(posedge clk) disable iff (!rst_b)
        reset_pin_enable |-> pad_pullup[sbio_pkg::RESET_PIN_IDX])
        else $error("pin three pull-up off");

    // ************************************************************
    // Latch, direction, source, pull-up, read and sampling checks
    // ************************************************************
    a_rmw_clear_bits: assert property (
        @(posedge clk) disable iff (!rst_b)
        reg_wr && reg_addr == sbio_pkg::OFF_PIN_CLR
        |=> output_latch_reg
            == ($past(pin_read) & ~$past(wdata_pins)))
        else $error("clear not read-modify-write");

    // Only the four latch writes may move it
    a_latch_holds: assert property (
        @(posedge clk) disable iff (!rst_b)
        !(wr_pin || wr_latch || wr_set || wr_clr)
        |=> $stable(output_latch_reg))
        else $error("latch changed without a write");

    a_dir_write_lands: assert property (
        @(posedge clk) disable iff (!rst_b)
        wr_dir
        |=> direction_reg == $past(wdata_pins))
        else $error("direction write lost");

    a_periph_drives_pin: assert property (
        @(posedge clk) disable iff (!rst_b)
        ((pad_out ^ periph_data) & peripheral_pin_select_reg & ~od_mask)
            == '0)
        else $error("peripheral pin not driving its data");

    a_twi_sinks_low: assert property (
        @(posedge clk) disable iff (!rst_b)
        (twi_own & ~periph_data & ~direction_reg & ~analog_out_en & ~pad_oe)
            == '0)
        else $error("two-wire pin not sinking");

    a_pullup_on_input: assert property (
        @(posedge clk) disable iff (!rst_b)
        (pullup_enable_reg & direction_reg & ~pad_pullup)
            == '0)
        else $error("pull-up missing on an input");

    a_read_idle_zero: assert property (
        @(posedge clk) disable iff (!rst_b)
        !reg_rd
        |=> reg_rdata == sbio_pkg::READ_ZERO)
        else $error("read data not dropped");

    // Two edges from pad to read, both stages out of reset
    a_pin_two_stages: assert property (
        @(posedge clk) disable iff (!rst_b)
        $past(rst_b) && $past(rst_b, 2)
        |-> pin_sync == $past(pad_in, 2))
        else $error("pin level not two stages late");

endmodule // sbio_port

// ===== testbench/sbio_pin_model.sv
// Purpose: Pin side of the port: resolves each pad wire level
// Assumes: One external source per pin, enabled by ext_en
// Notes:   An undriven, unpulled pin toggles every cycle
`timescale 1ns/1ps
module sbio_pin_model (
    // Clock
    input  wire logic                    clk,
    // Pad controls from the port
    input  wire sbio_pkg::sbio_pins_type pad_out,
    input  wire sbio_pkg::sbio_pins_type pad_oe,
    input  wire sbio_pkg::sbio_pins_type pad_pullup,
    // External driver
    input  wire sbio_pkg::sbio_pins_type ext_en,
    input  wire sbio_pkg::sbio_pins_type ext_val,
    // Resolved level
    output sbio_pkg::sbio_pins_type      pad_in
);
    sbio_pkg::sbio_pins_type float_reg = 6'h00;

    always @(posedge clk) begin
        float_reg <= ~float_reg;
    end

    // ************************************************************
    // Wire level
    // ************************************************************
    assign pad_in = (pad_oe & pad_out)
                  | (~pad_oe & ext_en & ext_val)
                  | (~pad_oe & ~ext_en & pad_pullup)
                  | (~pad_oe & ~ext_en & ~pad_pullup & float_reg);
endmodule // sbio_pin_model

// ===== testbench/test_six_bit_io_port.sv
// Purpose: Self-checking bench for the six-bit I/O port
// Assumes: Register port answers reads one cycle after the strobe
// Notes:   Pin 4 is held high externally; other inputs rely on pull-ups
`timescale 1ns/1ps
module test_six_bit_io_port;
    typedef struct packed {
        sbio_pkg::sbio_addr_type waddr;
        sbio_pkg::sbio_data_type wdata;
        sbio_pkg::sbio_addr_type raddr;
        sbio_pkg::sbio_data_type exp;
    } sbio_row_type;

    localparam sbio_row_type ROWS [10] = '{
        '{4'h2, 8'hc5, 4'h2, 8'h05}, '{4'h3, 8'h00, 4'h3, 8'h00},
        '{4'h4, 8'h12, 4'h4, 8'h12}, '{4'h5, 8'h0a, 4'h5, 8'h0a},
        '{4'h6, 8'h21, 4'h6, 8'h21}, '{4'h7, 8'h3f, 4'h7, 8'h3f},
        '{4'h8, 8'h00, 4'h8, 8'h00}, '{4'h1, 8'h2a, 4'h1, 8'h2a},
        '{4'h0, 8'h15, 4'h1, 8'h15}, '{4'hb, 8'hff, 4'hb, 8'h00}};
    localparam sbio_pkg::sbio_data_type RST_EXP [1:8] = '{
        8'h00, 8'h3f, 8'h3f, 8'h00, 8'h3f, 8'h3f, 8'h00, 8'h00};

    logic                    clk;
    logic                    rst_b;
    sbio_pkg::sbio_addr_type reg_addr;
    sbio_pkg::sbio_data_type reg_wdata;
    logic                    reg_wr;
    logic                    reg_rd;
    sbio_pkg::sbio_data_type reg_rdata;
    sbio_pkg::sbio_pins_type periph_data;
    sbio_pkg::sbio_pins_type twi_own;
    sbio_pkg::sbio_pins_type analog_out_en;
    logic                    reset_pin_enable;
    sbio_pkg::sbio_pins_type digital_in;
    sbio_pkg::sbio_pins_type pad_in;
    sbio_pkg::sbio_pins_type pad_out;
    sbio_pkg::sbio_pins_type pad_oe;
    sbio_pkg::sbio_pins_type pad_pullup;
    sbio_pkg::sbio_pins_type pad_slew_limit;
    sbio_pkg::sbio_pins_type pad_schmitt;
    sbio_pkg::sbio_pins_type pad_in_enable;
    sbio_pkg::sbio_pins_type ext_en;
    sbio_pkg::sbio_pins_type ext_val;
    int                      failures;
    int                      comparisons;

    sbio_port dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .periph_data(periph_data),
        .twi_own(twi_own), .analog_out_en(analog_out_en),
        .reset_pin_enable(reset_pin_enable), .digital_in(digital_in), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup),
        .pad_slew_limit(pad_slew_limit), .pad_schmitt(pad_schmitt),
        .pad_in_enable(pad_in_enable));

    sbio_pin_model pins (.clk(clk), .pad_out(pad_out), .pad_oe(pad_oe),
        .pad_pullup(pad_pullup), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic wr(input sbio_pkg::sbio_addr_type a, input sbio_pkg::sbio_data_type d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input sbio_pkg::sbio_addr_type a, output sbio_pkg::sbio_data_type d);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        complete_run();
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        sbio_pkg::sbio_data_type d;
        rst_b = 1'b0; reg_addr = 4'h0; reg_wdata = 8'h00; reg_wr = 1'b0; reg_rd = 1'b0;
        periph_data = 6'h00; twi_own = 6'h00; analog_out_en = 6'h00;
        reset_pin_enable = 1'b0; ext_en = 6'h10; ext_val = 6'h10;
        failures = 0; comparisons = 0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        foreach (ROWS[i]) begin
            wr(ROWS[i].waddr, ROWS[i].wdata);
            rd(ROWS[i].raddr, d);
            check("register row", d, ROWS[i].exp);
        end
        check("slew", {2'b00, pad_slew_limit}, 8'h0a);
        check("schmitt", {2'b00, pad_schmitt}, 8'h21);
        check("drive enable", {2'b00, pad_oe}, 8'h2a);
        check("pull-up", {2'b00, pad_pullup}, 8'h05);
        settle();
        rd(sbio_pkg::OFF_PIN_LEVEL, d);
        check("pin level", d, 8'h15);
        check("digital in", {2'b00, digital_in}, 8'h15);
        wr(sbio_pkg::OFF_ANALOG, 8'h09);
        check("analog drive", {2'b00, pad_oe}, 8'h2a);
        check("input enable", {2'b00, pad_in_enable}, 8'h36);
        settle();
        rd(sbio_pkg::OFF_PIN_LEVEL, d);
        check("analog read", d, 8'h14);
        check("analog digital in", {2'b00, digital_in}, 8'h14);
        wr(sbio_pkg::OFF_PIN_SET, 8'h20);
        rd(sbio_pkg::OFF_LATCH, d);
        check("pin set", d, 8'h34);
        settle();
        wr(sbio_pkg::OFF_PIN_CLR, 8'h04);
        rd(sbio_pkg::OFF_LATCH, d);
        check("pin clear", d, 8'h30);
        analog_out_en <= 6'h08;
        settle();
        check("analog out", {2'b00, pad_oe}, 8'h22);
        analog_out_en <= 6'h00;
        check("latch source", {2'b00, pad_out & 6'h20}, 8'h20);
        wr(sbio_pkg::OFF_PIN_SEL, 8'h20);
        check("periph source", {2'b00, pad_out & 6'h20}, 8'h00);
        settle();
        rd(sbio_pkg::OFF_PIN_LEVEL, d);
        check("periph pin read", d, 8'h14);
        periph_data <= 6'h08;
        twi_own     <= 6'h08;
        settle();
        check("two-wire release", {2'b00, pad_oe & 6'h08}, 8'h00);
        reset_pin_enable <= 1'b1;
        settle();
        check("reset pin pull", {2'b00, pad_pullup}, 8'h0d);
        rd(sbio_pkg::OFF_PULLUP, d);
        check("pull-up reg kept", d, 8'h3f);
        @(posedge clk);
        #1;
        check("read data drop", reg_rdata, 8'h00);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 1; i <= 8; i++) begin
            rd(i[3:0], d);
            check("reset value", d, RST_EXP[i]);
        end
        check("reset drive", {2'b00, pad_oe}, 8'h00);
        check("reset input", {2'b00, pad_in_enable}, 8'h00);
        complete_run();
    end
endmodule // test_six_bit_io_port
